// File: srbz_bank.sv
// bank-zero special register file: decode, indirect path, pc latch, ports
// assumes an async-read data memory on the mem_* port and peripherals
// that take their control bytes from the *_ctrl_o outputs
`timescale 1ns/1ps
`default_nettype none
module srbz_bank (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic por_reset_i,
  input wire logic reset_timeout_i,
  input wire logic reset_powerdown_i,
  input wire logic [8:0] addr_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic [8:0] mem_addr_o,
  output logic mem_we_o,
  output logic mem_re_o,
  output logic [7:0] mem_wdata_o,
  input wire logic [7:0] mem_rdata_i,
  input wire logic pc_inc_i,
  output logic [12:0] pc_o,
  input wire logic alu_flags_we_i,
  input wire logic [2:0] alu_flags_i,
  output logic [7:0] status_o,
  input wire logic timer0_ovf_i,
  input wire logic ext_pin_evt_i,
  input wire logic port_change_evt_i,
  input wire logic [7:0] periph_flags_1_set_i,
  input wire logic periph_flags_2_set_i,
  input wire logic ssp_write_collision_i,
  input wire logic ssp_rx_overflow_i,
  input wire logic rx_framing_error_i,
  input wire logic rx_overrun_error_i,
  input wire logic rx_bit9_i,
  input wire logic [7:0] rx_data_i,
  output logic [7:0] int_control_o,
  output logic [7:0] periph_flags_1_o,
  output logic [7:0] periph_flags_2_o,
  output logic [7:0] timer1_ctrl_o,
  output logic [7:0] timer2_ctrl_o,
  output logic [7:0] ssp_ctrl_o,
  output logic [7:0] ccp1_ctrl_o,
  output logic [7:0] ccp2_ctrl_o,
  output logic [7:0] rx_status_o,
  output logic periph_wr_o,
  output logic [6:0] periph_off_o,
  input wire logic ssp_clk_out_i,
  input wire logic ssp_clk_drive_i,
  input wire logic ssp_data_out_i,
  input wire logic ssp_data_drive_i,
  output logic ssp_clk_in_o,
  output logic ssp_data_in_o,
  input wire logic [5:0] port_a_in_i,
  input wire logic [7:0] port_b_in_i,
  input wire logic [7:0] port_c_in_i,
  input wire logic [7:0] port_d_in_i,
  input wire logic [2:0] port_e_in_i,
  input wire logic [32:0] port_dir_i,
  output logic [32:0] port_out_o,
  output logic [32:0] port_oe_o
);
  // offsets that stay visible from every bank
  function automatic logic is_mirror(input logic [6:0] off);
    is_mirror = (off == srbz_pkg::OFF_INDIRECT_PORT) ||
      (off == srbz_pkg::OFF_PC_LOW) || (off == srbz_pkg::OFF_CORE_STATUS) ||
      (off == srbz_pkg::OFF_IND_POINTER) ||
      (off == srbz_pkg::OFF_PC_HIGH_LATCH) ||
      (off == srbz_pkg::OFF_INT_CONTROL);
  endfunction

  // plain byte stores whose behaviour lives in the peripherals
  function automatic logic is_store(input logic [6:0] off);
    is_store = (off == srbz_pkg::OFF_TIMER0_COUNT) ||
      (off == srbz_pkg::OFF_TIMER1_LOW) || (off == srbz_pkg::OFF_TIMER1_HIGH) ||
      (off == srbz_pkg::OFF_TIMER2_COUNT) ||
      (off == srbz_pkg::OFF_SYNC_SERIAL_BUFFER) ||
      (off == srbz_pkg::OFF_CCP1_VALUE_LOW) ||
      (off == srbz_pkg::OFF_CCP1_VALUE_HIGH) ||
      (off == srbz_pkg::OFF_USART_TX_DATA) ||
      (off == srbz_pkg::OFF_CCP2_VALUE_LOW) ||
      (off == srbz_pkg::OFF_CCP2_VALUE_HIGH);
  endfunction

  function automatic logic [7:0] port_mask(input logic [2:0] idx);
    port_mask = (idx == 3'h0) ? srbz_pkg::PORT_A_MASK :
      (idx == 3'h4) ? srbz_pkg::PORT_E_MASK : srbz_pkg::PORT_FULL_MASK;
  endfunction

  logic [7:0] status_reg;
  logic [7:0] pointer_reg;
  logic [4:0] pc_latch_reg;
  logic [12:0] pc_reg;
  logic [7:0] int_reg;
  logic [7:0] pf1_reg;
  logic [7:0] pf2_reg;
  logic [7:0] t1_reg;
  logic [7:0] t2_reg;
  logic [7:0] ssc_reg;
  logic [7:0] ccp1_reg;
  logic [7:0] ccp2_reg;
  logic [7:0] rxs_reg;
  logic [7:0] store_reg [0:31];
  logic [7:0] port_lat_reg [0:4];
  logic [32:0] pin_meta_reg;
  logic [32:0] pin_sync_reg;
  logic [32:0] pout_reg;
  logic [32:0] poe_reg;
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  logic [8:0] eff_addr;
  logic [6:0] eff_off;
  logic internal;
  logic sfr_wr;
  logic [7:0] sfr_rd;
  logic ssp_on;
  logic two_wire;

  // indirect redirect, then split between this file and data memory
  always_comb
  begin
    eff_addr = addr_i;
    if (addr_i[6:0] == srbz_pkg::OFF_INDIRECT_PORT)
      eff_addr = {status_reg[srbz_pkg::ST_BANK_HI], pointer_reg};
    eff_off = eff_addr[6:0];
    internal = (eff_off < srbz_pkg::OFF_SFR_LIMIT) &&
      ((eff_addr[8:7] == 2'b00) || is_mirror(eff_off));
    sfr_wr = wr_en_i && internal;
  end

  // data memory port; only reached for non-register addresses
  assign mem_addr_o = eff_addr;
  assign mem_we_o = wr_en_i && !internal;
  assign mem_re_o = rd_en_i && !internal;
  assign mem_wdata_o = wdata_i;
  assign periph_wr_o = sfr_wr && is_store(eff_off);
  assign periph_off_o = eff_off;

  // read mux; indirect through a zero pointer lands here and reads zero
  always_comb
  begin
    sfr_rd = srbz_pkg::ZERO_BYTE;
    if (is_store(eff_off))
      sfr_rd = store_reg[eff_off[4:0]];
    else if (eff_off >= srbz_pkg::OFF_PORT_FIRST &&
             eff_off <= srbz_pkg::OFF_PORT_LAST)
    begin
      unique case (eff_off[3:0])
        4'h5: sfr_rd = {2'b00, pin_sync_reg[5:0]};
        4'h6: sfr_rd = pin_sync_reg[13:6];
        4'h7: sfr_rd = pin_sync_reg[21:14];
        4'h8: sfr_rd = pin_sync_reg[29:22];
        default: sfr_rd = {5'h00, pin_sync_reg[32:30]};
      endcase
    end
    else
    begin
      case (eff_off)
        srbz_pkg::OFF_PC_LOW: sfr_rd = pc_reg[7:0];
        srbz_pkg::OFF_CORE_STATUS: sfr_rd = status_reg;
        srbz_pkg::OFF_IND_POINTER: sfr_rd = pointer_reg;
        srbz_pkg::OFF_PC_HIGH_LATCH: sfr_rd = {3'h0, pc_latch_reg};
        srbz_pkg::OFF_INT_CONTROL: sfr_rd = int_reg;
        srbz_pkg::OFF_PERIPH_FLAGS_1: sfr_rd = pf1_reg;
        srbz_pkg::OFF_PERIPH_FLAGS_2: sfr_rd = pf2_reg;
        srbz_pkg::OFF_TIMER1_CONTROL: sfr_rd = t1_reg;
        srbz_pkg::OFF_TIMER2_CONTROL: sfr_rd = t2_reg;
        srbz_pkg::OFF_SYNC_SERIAL_CONTROL: sfr_rd = ssc_reg;
        srbz_pkg::OFF_CCP1_CONTROL: sfr_rd = ccp1_reg;
        srbz_pkg::OFF_CCP2_CONTROL: sfr_rd = ccp2_reg;
        srbz_pkg::OFF_USART_RX_DATA: sfr_rd = rx_data_i;
        srbz_pkg::OFF_USART_RX_STATUS: sfr_rd = {rxs_reg[7:4], 1'b0,
          rx_framing_error_i, rx_overrun_error_i, rx_bit9_i};
        default: sfr_rd = srbz_pkg::ZERO_BYTE;
      endcase
    end
  end

  // registered read data, one cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      rdata_reg <= srbz_pkg::ZERO_BYTE;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rvalid_reg <= rd_en_i;
      if (rd_en_i)
        rdata_reg <= internal ? sfr_rd : mem_rdata_i;
    end
  end

  // status: bank bits writable, timeout/powerdown owned by reset logic
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      if (por_reset_i)
        status_reg <= srbz_pkg::STATUS_POR_VALUE;
      else
        status_reg <= {3'b000, reset_timeout_i, reset_powerdown_i,
                       status_reg[2:0]};
    end
    else
    begin
      if (sfr_wr && eff_off == srbz_pkg::OFF_CORE_STATUS)
        status_reg <= (wdata_i & srbz_pkg::STATUS_WR_MASK) |
                      (status_reg & ~srbz_pkg::STATUS_WR_MASK);
      // alu result wins over a same-cycle software write of the flags
      if (alu_flags_we_i)
        status_reg[2:0] <= alu_flags_i;
    end
  end

  // indirect pointer, kept over warm resets
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      if (por_reset_i)
        pointer_reg <= srbz_pkg::ZERO_BYTE;
    end
    else if (sfr_wr && eff_off == srbz_pkg::OFF_IND_POINTER)
      pointer_reg <= wdata_i;
  end

  // program counter; the high latch reaches the pc only on a low-byte load
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      pc_latch_reg <= 5'h00;
      pc_reg <= 13'h0000;
    end
    else
    begin
      if (sfr_wr && eff_off == srbz_pkg::OFF_PC_HIGH_LATCH)
        pc_latch_reg <= wdata_i[4:0];
      if (sfr_wr && eff_off == srbz_pkg::OFF_PC_LOW)
        pc_reg <= {pc_latch_reg, wdata_i};
      else if (pc_inc_i)
        pc_reg <= pc_reg + 13'h0001;
    end
  end

  // interrupt control; events set regardless of enables, set beats clear
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      if (por_reset_i)
        int_reg <= srbz_pkg::ZERO_BYTE;
      else
        int_reg <= {7'h00, int_reg[srbz_pkg::IC_PORT_CHANGE_FLAG]};
    end
    else
    begin
      if (sfr_wr && eff_off == srbz_pkg::OFF_INT_CONTROL)
        int_reg <= wdata_i;
      if (timer0_ovf_i)
        int_reg[srbz_pkg::IC_TIMER0_FLAG] <= 1'b1;
      if (ext_pin_evt_i)
        int_reg[srbz_pkg::IC_EXT_PIN_FLAG] <= 1'b1;
      if (port_change_evt_i)
        int_reg[srbz_pkg::IC_PORT_CHANGE_FLAG] <= 1'b1;
    end
  end

  // peripheral flags; reserved bit 6 is never stored
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      pf1_reg <= srbz_pkg::ZERO_BYTE;
      pf2_reg <= srbz_pkg::ZERO_BYTE;
    end
    else
    begin
      pf1_reg <= ((sfr_wr && eff_off == srbz_pkg::OFF_PERIPH_FLAGS_1) ?
        wdata_i : pf1_reg) | periph_flags_1_set_i;
      pf2_reg <= ((sfr_wr && eff_off == srbz_pkg::OFF_PERIPH_FLAGS_2) ?
        wdata_i : pf2_reg) | {7'h00, periph_flags_2_set_i};
      pf1_reg[6] <= 1'b0;
      pf2_reg[7:1] <= 7'h00;
    end
  end

  // timer control bytes
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      if (por_reset_i)
        t1_reg <= srbz_pkg::ZERO_BYTE;
      t2_reg <= srbz_pkg::ZERO_BYTE;
    end
    else
    begin
      if (sfr_wr && eff_off == srbz_pkg::OFF_TIMER1_CONTROL)
        t1_reg <= wdata_i & srbz_pkg::TIMER1_CTRL_MASK;
      if (sfr_wr && eff_off == srbz_pkg::OFF_TIMER2_CONTROL)
        t2_reg <= wdata_i & srbz_pkg::TIMER2_CTRL_MASK;
    end
  end

  // serial control, capture control and usart receive control
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      ssc_reg <= srbz_pkg::ZERO_BYTE;
      ccp1_reg <= srbz_pkg::ZERO_BYTE;
      ccp2_reg <= srbz_pkg::ZERO_BYTE;
      rxs_reg <= srbz_pkg::ZERO_BYTE;
    end
    else
    begin
      if (sfr_wr && eff_off == srbz_pkg::OFF_SYNC_SERIAL_CONTROL)
        ssc_reg <= wdata_i;
      if (ssp_write_collision_i)
        ssc_reg[srbz_pkg::SSC_WRITE_COLLISION] <= 1'b1;
      if (ssp_rx_overflow_i)
        ssc_reg[srbz_pkg::SSC_RX_OVERFLOW] <= 1'b1;
      if (sfr_wr && eff_off == srbz_pkg::OFF_CCP1_CONTROL)
        ccp1_reg <= wdata_i & srbz_pkg::CCP_CTRL_MASK;
      if (sfr_wr && eff_off == srbz_pkg::OFF_CCP2_CONTROL)
        ccp2_reg <= wdata_i & srbz_pkg::CCP_CTRL_MASK;
      if (sfr_wr && eff_off == srbz_pkg::OFF_USART_RX_STATUS)
        rxs_reg <= wdata_i & srbz_pkg::RX_STATUS_WR_MASK;
    end
  end

  // byte stores; timer2 count and transmit data clear on every reset
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      for (int i = 0; i < 32; i++)
        if (por_reset_i || i == int'(srbz_pkg::OFF_TIMER2_COUNT) ||
            i == int'(srbz_pkg::OFF_USART_TX_DATA))
          store_reg[i] <= srbz_pkg::ZERO_BYTE;
    end
    else if (sfr_wr && is_store(eff_off))
      store_reg[eff_off[4:0]] <= wdata_i;
  end

  // port output latches, never read back through the register path
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      if (por_reset_i)
        for (int i = 0; i < 5; i++)
          port_lat_reg[i] <= srbz_pkg::ZERO_BYTE;
    end
    else if (sfr_wr && eff_off >= srbz_pkg::OFF_PORT_FIRST &&
             eff_off <= srbz_pkg::OFF_PORT_LAST)
      port_lat_reg[3'(eff_off - srbz_pkg::OFF_PORT_FIRST)] <= wdata_i &
        port_mask(3'(eff_off - srbz_pkg::OFF_PORT_FIRST));
  end

  // two-stage pin synchroniser; only the second stage is read
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end
    else
    begin
      pin_meta_reg <= {port_e_in_i, port_d_in_i, port_c_in_i, port_b_in_i,
                       port_a_in_i};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // serial port ownership of port c; modes below the threshold are 4-wire
  assign ssp_on = ssc_reg[srbz_pkg::SSC_PORT_ENABLE];
  assign two_wire = ssc_reg[3:0] >= srbz_pkg::SSC_TWO_WIRE_MIN;
  assign ssp_clk_in_o = pin_sync_reg[17];
  assign ssp_data_in_o = pin_sync_reg[18];

  // pin drivers are registered; costs one cycle on the serial clock path
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      pout_reg <= '0;
      poe_reg <= '0;
    end
    else
    begin
      pout_reg <= {port_lat_reg[4][2:0], port_lat_reg[3], port_lat_reg[2],
                   port_lat_reg[1], port_lat_reg[0][5:0]};
      poe_reg <= port_dir_i;
      if (ssp_on)
      begin
        pout_reg[17] <= ssp_clk_out_i;
        poe_reg[17] <= ssp_clk_drive_i;
        if (two_wire)
        begin
          pout_reg[18] <= ssp_data_out_i;
          poe_reg[18] <= ssp_data_drive_i;
        end
        else
        begin
          poe_reg[18] <= 1'b0;
          pout_reg[19] <= ssp_data_out_i;
        end
      end
    end
  end

  assign port_out_o = pout_reg;
  assign port_oe_o = poe_reg;
  assign rdata_o = rdata_reg;
  assign rvalid_o = rvalid_reg;
  assign pc_o = pc_reg;
  assign status_o = status_reg;
  assign int_control_o = int_reg;
  assign periph_flags_1_o = pf1_reg;
  assign periph_flags_2_o = pf2_reg;
  assign timer1_ctrl_o = t1_reg;
  assign timer2_ctrl_o = t2_reg;
  assign ssp_ctrl_o = ssc_reg;
  assign ccp1_ctrl_o = ccp1_reg;
  assign ccp2_ctrl_o = ccp2_reg;
  assign rx_status_o = {rxs_reg[7:4], 1'b0, rx_framing_error_i,
                        rx_overrun_error_i, rx_bit9_i};

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_indirect_route: assert property (
    wr_en_i && addr_i[6:0] == 7'h00 && !internal |->
      mem_we_o && mem_addr_o == {status_reg[7], pointer_reg})
    else $error("indirect write not routed through pointer");
  a_port_pins_read: assert property (
    rd_en_i && addr_i == 9'h006 |=> rdata_o == $past(pin_sync_reg[13:6]))
    else $error("port read did not return pin levels");
  a_pc_load: assert property (
    wr_en_i && internal && eff_off == 7'h02 |=>
      pc_reg == {$past(pc_latch_reg), $past(wdata_i)})
    else $error("pc load did not use high latch");
  a_mirror_bank3: assert property (
    wr_en_i && addr_i == 9'h18b && !timer0_ovf_i && !ext_pin_evt_i &&
      !port_change_evt_i |=> int_reg == $past(wdata_i))
    else $error("mirrored register missed in bank 3");
  a_unimpl_zero: assert property (
    rd_en_i && addr_i == 9'h01e |=> rdata_o == 8'h00)
    else $error("unimplemented location read nonzero");
  a_por_status: assert property (@(posedge clk_i) disable iff (1'b0)
    !resetn_i && por_reset_i |=> status_reg == 8'h18)
    else $error("status power-on value wrong");
  a_warm_timer1: assert property (@(posedge clk_i) disable iff (1'b0)
    !resetn_i && !por_reset_i |=> t1_reg == $past(t1_reg))
    else $error("timer1 control changed on warm reset");
  a_timer2_top: assert property (
    timer2_ctrl_o[7] == 1'b0 && ccp1_ctrl_o[7:6] == 2'b00)
    else $error("reserved control bits set");
  a_flag_set_wins: assert property (
    timer0_ovf_i |=> int_reg[2] ##1 (int_reg[2] || $past(sfr_wr)))
    else $error("timer0 flag lost");
  a_reserved_flag: assert property (
    ##1 pf1_reg[6] == 1'b0)
    else $error("reserved flag bit stored");
  a_serial_clk_pin: assert property (
    ssp_on |=> pout_reg[17] == $past(ssp_clk_out_i) &&
      poe_reg[17] == $past(ssp_clk_drive_i))
    else $error("serial clock not on port c bit 3");
  c_indirect_write: cover property (wr_en_i && addr_i[6:0] == 7'h00);
  c_pc_load: cover property (wr_en_i && addr_i == 9'h00a ##1
    wr_en_i && addr_i == 9'h002);
  c_two_wire: cover property (ssp_on && two_wire && poe_reg[18]);
endmodule
`default_nettype wire

// File: srbz_mem_model.sv
// data-memory model behind the core port of the bank-zero file
// assumes nine-bit effective addresses and async reads
`timescale 1ns/1ps
`default_nettype none
module srbz_mem_model (
  input wire logic clk_i,
  input wire logic [8:0] mem_addr_i,
  input wire logic mem_we_i,
  input wire logic mem_re_i,
  input wire logic [7:0] mem_wdata_i,
  output logic [7:0] mem_rdata_o
);
  logic [7:0] mem_reg [512];
  // unselected reads show the inverse so a stale byte never matches
  assign mem_rdata_o = mem_re_i ? mem_reg[mem_addr_i] : ~mem_reg[mem_addr_i];
  // store on the edge where the core strobes a write
  always_ff @(posedge clk_i)
  begin
    if (mem_we_i)
    begin
      mem_reg[mem_addr_i] <= mem_wdata_i;
    end
  end
endmodule
`default_nettype wire

// File: srbz_pkg.sv
// constants for the bank-zero special register file of an 8-bit core
// assumes the core presents nine-bit data-memory addresses, bank in [8:7]
// Summary of operation
// - offset zero accesses the data byte addressed by the indirect pointer
// - port writes load the output latch; port reads return pin levels
// - pc high bits reach the counter only through a five-bit latch
// - six core registers decode at the same offset in every bank
// - power-on loads first reset set; warm resets load second set
// - unimplemented locations and bits read as zero
// - status powers up 0001 1xxx; warm reset clears banks, keeps flags
// - timer1 control fields; cleared at power-on, kept on warm reset
// - timer2 control fields; bit 7 reads zero; cleared on any reset
// - sync serial control fields; cleared on any reset
// - interrupt control enables and flags; port-change flag undefined
// - first peripheral flag register layout, cleared on reset
// - capture compare control: duty bits 5:4, mode 3:0, upper zero
// - port c bit 3 carries the serial clock when serial port is on
// - port c bit 4 serial data in or bus data; bit 5 data out
// - interrupt flags set on their event whatever the enables
package srbz_pkg;
  localparam int ADDR_W = 9;
  localparam int OFF_W = 7;
  localparam int PC_W = 13;
  localparam int PIN_W = 33;
  localparam logic [6:0] OFF_INDIRECT_PORT = 7'h00;
  localparam logic [6:0] OFF_TIMER0_COUNT = 7'h01;
  localparam logic [6:0] OFF_PC_LOW = 7'h02;
  localparam logic [6:0] OFF_CORE_STATUS = 7'h03;
  localparam logic [6:0] OFF_IND_POINTER = 7'h04;
  localparam logic [6:0] OFF_PORT_FIRST = 7'h05;
  localparam logic [6:0] OFF_PORT_LAST = 7'h09;
  localparam logic [6:0] OFF_PC_HIGH_LATCH = 7'h0a;
  localparam logic [6:0] OFF_INT_CONTROL = 7'h0b;
  localparam logic [6:0] OFF_PERIPH_FLAGS_1 = 7'h0c;
  localparam logic [6:0] OFF_PERIPH_FLAGS_2 = 7'h0d;
  localparam logic [6:0] OFF_TIMER1_LOW = 7'h0e;
  localparam logic [6:0] OFF_TIMER1_HIGH = 7'h0f;
  localparam logic [6:0] OFF_TIMER1_CONTROL = 7'h10;
  localparam logic [6:0] OFF_TIMER2_COUNT = 7'h11;
  localparam logic [6:0] OFF_TIMER2_CONTROL = 7'h12;
  localparam logic [6:0] OFF_SYNC_SERIAL_BUFFER = 7'h13;
  localparam logic [6:0] OFF_SYNC_SERIAL_CONTROL = 7'h14;
  localparam logic [6:0] OFF_CCP1_VALUE_LOW = 7'h15;
  localparam logic [6:0] OFF_CCP1_VALUE_HIGH = 7'h16;
  localparam logic [6:0] OFF_CCP1_CONTROL = 7'h17;
  localparam logic [6:0] OFF_USART_RX_STATUS = 7'h18;
  localparam logic [6:0] OFF_USART_TX_DATA = 7'h19;
  localparam logic [6:0] OFF_USART_RX_DATA = 7'h1a;
  localparam logic [6:0] OFF_CCP2_VALUE_LOW = 7'h1b;
  localparam logic [6:0] OFF_CCP2_VALUE_HIGH = 7'h1c;
  localparam logic [6:0] OFF_CCP2_CONTROL = 7'h1d;
  localparam logic [6:0] OFF_SFR_LIMIT = 7'h20;
  localparam logic [7:0] PORT_A_MASK = 8'h3f;
  localparam logic [7:0] PORT_E_MASK = 8'h07;
  localparam logic [7:0] PORT_FULL_MASK = 8'hff;
  localparam logic [7:0] PC_LATCH_MASK = 8'h1f;
  localparam logic [7:0] TIMER1_CTRL_MASK = 8'h3f;
  localparam logic [7:0] TIMER2_CTRL_MASK = 8'h7f;
  localparam logic [7:0] CCP_CTRL_MASK = 8'h3f;
  localparam logic [7:0] PERIPH_FLAGS_1_MASK = 8'hbf;
  localparam logic [7:0] PERIPH_FLAGS_2_MASK = 8'h01;
  localparam logic [7:0] RX_STATUS_WR_MASK = 8'hf0;
  localparam logic [7:0] STATUS_WR_MASK = 8'he7;
  localparam logic [7:0] STATUS_POR_VALUE = 8'h18;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam int ST_BANK_HI = 7;
  localparam int ST_TIMEOUT = 4;
  localparam int ST_POWERDOWN = 3;
  localparam int IC_TIMER0_FLAG = 2;
  localparam int IC_EXT_PIN_FLAG = 1;
  localparam int IC_PORT_CHANGE_FLAG = 0;
  localparam int SSC_WRITE_COLLISION = 7;
  localparam int SSC_RX_OVERFLOW = 6;
  localparam int SSC_PORT_ENABLE = 5;
  localparam logic [3:0] SSC_TWO_WIRE_MIN = 4'h6;
endpackage

// File: tb_special_register_bank_zero.sv
// testbench for the bank-zero register file with a data-memory model
// assumes inputs change at falling edges, design samples at rising
`timescale 1ns/1ps
`default_nettype none
module tb_special_register_bank_zero;
  logic clk_i = 1'b0, resetn_i = 1'b0, por_reset_i = 1'b1;
  logic wr_en_i = 1'b0, rd_en_i = 1'b0, pc_inc_i = 1'b0;
  logic alu_flags_we_i = 1'b0, reset_timeout_i = 1'b1;
  logic [2:0] alu_flags_i = 3'h0;
  logic [8:0] addr_i = 9'h000;
  logic [7:0] wdata_i = 8'h00, rx_data_i = 8'h3c, periph_flags_1_set_i = 8'h00;
  logic [12:0] ev = 13'h0000;
  logic [7:0] port_b_in_i = 8'hc3, port_c_in_i = 8'h08;
  logic [7:0] rdata_o, mem_rdata_i, mem_wdata_o, int_control_o;
  logic [7:0] periph_flags_1_o, periph_flags_2_o, ssp_ctrl_o, rx_status_o;
  logic [8:0] mem_addr_o;
  logic [12:0] pc_o;
  logic [32:0] port_out_o, port_oe_o;
  logic rvalid_o, mem_we_o, mem_re_o, ssp_clk_in_o, ssp_data_in_o;
  int num_errors = 0;
  int total_checks = 0;
  always #5 clk_i = ~clk_i;
  srbz_bank u_srbz_bank (.clk_i, .resetn_i, .por_reset_i, .reset_timeout_i,
    .reset_powerdown_i(1'b0), .addr_i, .wr_en_i, .rd_en_i, .wdata_i,
    .rdata_o, .rvalid_o, .mem_addr_o, .mem_we_o, .mem_re_o, .mem_wdata_o,
    .mem_rdata_i, .pc_inc_i, .pc_o, .alu_flags_we_i, .alu_flags_i,
    .status_o(), .timer0_ovf_i(ev[12]), .ext_pin_evt_i(ev[0]),
    .port_change_evt_i(ev[1]), .periph_flags_1_set_i,
    .periph_flags_2_set_i(ev[2]), .ssp_write_collision_i(ev[3]),
    .ssp_rx_overflow_i(ev[4]), .rx_framing_error_i(ev[5]),
    .rx_overrun_error_i(ev[6]), .rx_bit9_i(ev[7]), .rx_data_i,
    .int_control_o, .periph_flags_1_o, .periph_flags_2_o, .timer1_ctrl_o(),
    .timer2_ctrl_o(), .ssp_ctrl_o, .ccp1_ctrl_o(), .ccp2_ctrl_o(),
    .rx_status_o, .periph_wr_o(), .periph_off_o(), .ssp_clk_out_i(ev[8]),
    .ssp_clk_drive_i(ev[9]), .ssp_data_out_i(ev[10]),
    .ssp_data_drive_i(ev[11]), .ssp_clk_in_o, .ssp_data_in_o,
    .port_a_in_i(6'h00), .port_b_in_i, .port_c_in_i, .port_d_in_i(8'h00),
    .port_e_in_i(3'h0), .port_dir_i(33'h1ffffffff), .port_out_o, .port_oe_o);
  srbz_mem_model u_srbz_mem_model (.clk_i, .mem_addr_i(mem_addr_o),
    .mem_we_i(mem_we_o), .mem_re_i(mem_re_o), .mem_wdata_i(mem_wdata_o),
    .mem_rdata_o(mem_rdata_i));
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // one write strobe over a single rising edge, then an idle cycle
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    addr_i = a;
    wdata_i = d;
    wr_en_i = 1'b1;
    cyc(1);
    wr_en_i = 1'b0;
    cyc(1);
  endtask
  // read strobe, then a bounded wait for the one-cycle answer
  task automatic rd(input logic [8:0] a, input logic [7:0] exp);
    int n;
    addr_i = a;
    rd_en_i = 1'b1;
    cyc(1);
    rd_en_i = 1'b0;
    for (n = 0; n < 4 && rvalid_o !== 1'b1; n++)
      cyc(1);
    if (n == 4)
    begin
      num_errors++;
      $display("ERROR %0t no read answer", $time);
    end
    else
      chk({5'h00, rdata_o}, {5'h00, exp});
    cyc(1);
  endtask
  task automatic t_map();
    rd(9'h003, 8'h18);
    wr(9'h004, 8'h25);
    wr(9'h000, 8'ha5);
    rd(9'h000, 8'ha5);
    wr(9'h184, 8'h30);
    rd(9'h004, 8'h30);
    wr(9'h18b, 8'ha8);
    rd(9'h00b, 8'ha8);
    wr(9'h006, 8'h5a);
    rd(9'h006, 8'hc3);
    chk(port_out_o[13:6], 8'h5a);
    wr(9'h08a, 8'hff);
    wr(9'h002, 8'h34);
    cyc(1);
    chk(pc_o, 13'h1f34);
    pc_inc_i = 1'b1;
    cyc(1);
    pc_inc_i = 1'b0;
    chk(pc_o, 13'h1f35);
    rd(9'h00a, 8'h1f);
    wr(9'h01e, 8'hff);
    rd(9'h01e, 8'h00);
    wr(9'h01a, 8'h00);
    rd(9'h01a, 8'h3c);
    wr(9'h012, 8'hff);
    rd(9'h012, 8'h7f);
    wr(9'h017, 8'hff);
    rd(9'h017, 8'h3f);
    $display("map test done");
  endtask
  task automatic t_events();
    ev = 13'h1fff;
    periph_flags_1_set_i = 8'hff;
    cyc(1);
    chk(rx_status_o[2:0], 3'h7);
    ev = 13'h0400;
    periph_flags_1_set_i = 8'h00;
    cyc(1);
    chk(int_control_o[2:0], 3'h7);
    chk(periph_flags_1_o, 8'hbf);
    chk(ssp_ctrl_o[7:6], 2'h3);
    chk(periph_flags_2_o, 8'h01);
    wr(9'h00c, 8'h00);
    rd(9'h00c, 8'h00);
    wr(9'h014, 8'h20);
    cyc(3);
    chk(port_out_o[19], 1'b1);
    chk(port_oe_o[18], 1'b0);
    chk({ssp_clk_in_o, ssp_data_in_o}, 2'h2);
    chk(port_oe_o[17], 1'b0);
    // two-wire mode hands bit 4 to the serial unit
    ev = 13'h0c00;
    wr(9'h014, 8'h26);
    cyc(2);
    chk(port_oe_o[18], 1'b1);
    chk(port_out_o[18], 1'b1);
    $display("event test done");
  endtask
  task automatic t_warm();
    wr(9'h010, 8'h3f);
    alu_flags_we_i = 1'b1;
    alu_flags_i = 3'h5;
    cyc(1);
    alu_flags_we_i = 1'b0;
    por_reset_i = 1'b0;
    resetn_i = 1'b0;
    cyc(2);
    resetn_i = 1'b1;
    rd(9'h010, 8'h3f);
    rd(9'h012, 8'h00);
    rd(9'h003, 8'h15);
    rd(9'h00b, 8'h01);
    $display("warm reset test done");
  endtask
  initial
  begin
    cyc(4);
    resetn_i = 1'b1;
    t_map();
    t_events();
    t_warm();
    stop_test();
  end
endmodule
`default_nettype wire
